// [ptd_defs.svh]
/*
 * Register offsets, field positions, reset values and timing counts for the PHY test and
 * diagnostic control register group.
 * Assumes it is included by its bare name from the design modules.
 */
`ifndef PTD_DEFS_SVH
`define PTD_DEFS_SVH

// ****************************************************************************
// Register offsets on the six-bit management register address.
// ****************************************************************************
`define PTD_OFS_TEN_MEG     5'h1A
`define PTD_OFS_BIST_CNT    5'h1B
`define PTD_OFS_BIST_LEN    5'h1C
`define PTD_OFS_CABLE_DIAG  5'h1E
`define PTD_OFS_PHY_RESET   5'h1F
`define PTD_OFS_MLED        6'h25

// ****************************************************************************
// Field positions.
// ****************************************************************************
`define PTD_BIT_POLARITY    4
`define PTD_BIT_JABBER      0
`define PTD_BIT_CNT_LOCK    15
`define PTD_BIT_DIAG_START  15
`define PTD_BIT_RESCAL      14
`define PTD_BIT_DIAG_DONE   1
`define PTD_BIT_DIAG_FAIL   0
`define PTD_BIT_HARD_RST    15
`define PTD_BIT_SOFT_RST    14
`define PTD_BIT_MLED_SWAP   9
`define PTD_MSK_MLED_CFG    16'h0079

// ****************************************************************************
// Reset values and timing.
// ****************************************************************************
`define PTD_RST_GAP         8'h7D
`define PTD_RST_LEN         11'h5EE
`define PTD_RST_MLED        16'h0041
`define PTD_GAP_SCALE       4
`define PTD_CNT_MAX         8'hFF
`define PTD_PULSE_NS        20
`define PTD_CLK_NS          10
`define PTD_PULSE_CYC       ((`PTD_PULSE_NS + `PTD_CLK_NS - 1) / `PTD_CLK_NS)
`define PTD_STRAP_WAIT      4

`endif

// [ptd_pkg.sv]
/*
 * Types shared by the PHY test and diagnostic control registers.
 * Assumes the management access is a simple read and write strobe with address.
 */
package ptd_pkg;
   typedef logic [15:0] ptd_word_t;
   typedef logic [5:0]  ptd_addr_t;
   typedef enum logic [1:0] {
      PTD_RST_IDLE  = 2'b00,
      PTD_RST_PULSE = 2'b01
   } ptd_rst_state_e;
endpackage

// [ptd_sync3.sv]
/*
 * Three flop synchroniser with agreement filter for one pin level.
 * Assumes the input is asynchronous to clk_sys_in.
 */
`include "ptd_defs.svh"
module ptd_sync3 (
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   input  wire logic pin_in,
   output logic      level_out
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_level;

   always_comb begin
      next_stage = {stage[1:0], pin_in};
      next_level = (stage[2] == stage[1]) ? stage[2] : level_out;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         stage     <= 3'h0;
         level_out <= 1'b0;
      end else begin
         stage     <= next_stage;
         level_out <= next_level;
      end
   end
endmodule

// [ptd_regs.sv]
/*
 * Management registers for polarity status, jabber control, packet generator setup,
 * PRBS error count, cable diagnostics, software resets and LED polarity.
 * Assumes the management serial engine presents one-cycle read and write strobes with a
 * six-bit register address on clk_sys_in, and that the diagnostic engine, BIST datapath
 * and LED logic outside drive the event inputs synchronously.
 */
//
// Function
// - Polarity bit mirrors status, cleared by reading here
// - Polarity one means inverted, zero correct
// - Jabber disable bit, effective only at 10M
// - Upper byte holds latched errored byte count
// - Write one bit15 latches count, clears counter
// - Gap field times four bytes, reset 0x7D
// - Packet length eleven bits, reset 0x5EE
// - Diagnostic start clears itself when done
// - Done bit set when measurement completes
// - Fail bit set when measurement fails
// - Writing bit14 starts resistor calibration
// - Bit15 self-clearing full PHY hard reset
// - Bit14 self-clearing restart, registers kept
// - LED polarity from collision strap, bit9 swaps
`include "ptd_defs.svh"
module ptd_regs (
   input  wire logic              clk_sys_in,
   input  wire logic              rst_in,
   input  wire logic              wr_strobe_in,
   input  wire logic              rd_strobe_in,
   input  wire ptd_pkg::ptd_addr_t addr_in,
   input  wire ptd_pkg::ptd_word_t wr_data_in,
   output ptd_pkg::ptd_word_t      rd_data_out,
   input  wire logic              polarity_inverted_in,
   input  wire logic              phy_status_rd_in,
   input  wire logic              speed_10m_in,
   input  wire logic              prbs_byte_err_in,
   input  wire logic              cnt_stop_mode_in,
   input  wire logic              diag_done_in,
   input  wire logic              diag_fail_in,
   input  wire logic              col_strap_pin_in,
   output logic                   polarity_status_out,
   output logic                   jabber_disable_out,
   output logic [9:0]             selftest_gap_bytes_out,
   output logic [10:0]            selftest_frame_bytes_out,
   output logic                   diag_start_out,
   output logic                   rescal_start_out,
   output logic                   hard_reset_out,
   output logic                   soft_restart_out,
   output logic                   mled_active_low_out,
   output logic [3:0]             mled_config_out,
   output logic                   mled_route_out
);
   // ************************************************************************
   // Decode.
   // ************************************************************************
   logic wr_ten;
   logic wr_cnt;
   logic wr_len;
   logic wr_diag;
   logic wr_rst;
   logic wr_mled;
   logic rd_ten;
   assign wr_ten  = wr_strobe_in && (addr_in == {1'b0, `PTD_OFS_TEN_MEG});
   assign wr_cnt  = wr_strobe_in && (addr_in == {1'b0, `PTD_OFS_BIST_CNT});
   assign wr_len  = wr_strobe_in && (addr_in == {1'b0, `PTD_OFS_BIST_LEN});
   assign wr_diag = wr_strobe_in && (addr_in == {1'b0, `PTD_OFS_CABLE_DIAG});
   assign wr_rst  = wr_strobe_in && (addr_in == {1'b0, `PTD_OFS_PHY_RESET});
   assign wr_mled = wr_strobe_in && (addr_in == `PTD_OFS_MLED);
   assign rd_ten  = rd_strobe_in && (addr_in == {1'b0, `PTD_OFS_TEN_MEG});

   // ************************************************************************
   // Strap capture.
   // ************************************************************************
   logic col_level;
   logic strap_taken, next_strap_taken;
   logic strap_high, next_strap_high;

   // The strap is taken once after reset, so a pin that moves later changes nothing.
   ptd_sync3 u_col_sync (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .pin_in     (col_strap_pin_in),
      .level_out  (col_level)
   );

   // ************************************************************************
   // Register state.
   // ************************************************************************
   logic        polarity, next_polarity;
   logic        jabber, next_jabber;
   logic [7:0]  err_run, next_err_run;
   logic [7:0]  err_held, next_err_held;
   logic [7:0]  gap, next_gap;
   logic [10:0] frame_len, next_frame_len;
   logic        diag_start, next_diag_start;
   logic        rescal, next_rescal;
   logic        diag_done, next_diag_done;
   logic        diag_fail, next_diag_fail;
   logic        mled_swap, next_mled_swap;
   logic [3:0]  mled_cfg, next_mled_cfg;
   logic        mled_route, next_mled_route;
   logic        hard_rst, next_hard_rst;
   logic        soft_rst, next_soft_rst;
   logic [3:0]  pulse_cnt, next_pulse_cnt;
   logic [2:0]  strap_wait, next_strap_wait;
   ptd_pkg::ptd_rst_state_e rst_state, next_rst_state;
   ptd_pkg::ptd_word_t next_rd_data;

   localparam logic [3:0]  PULSE_CYC  = 4'(`PTD_PULSE_CYC);
   localparam logic [2:0]  STRAP_WAIT = 3'(`PTD_STRAP_WAIT);
   localparam logic [15:0] MLED_RST   = `PTD_RST_MLED;

   always_comb begin
      next_strap_wait  = strap_taken ? strap_wait : strap_wait + 3'h1;
      // The filtered level needs a few edges after reset before it can be trusted.
      next_strap_taken = strap_taken || (strap_wait == STRAP_WAIT);
      next_strap_high  = strap_taken ? strap_high : col_level;
      // A new inverted detection in the clearing read cycle survives the clear.
      next_polarity = polarity_inverted_in ? 1'b1 : (rd_ten ? 1'b0 : polarity);
      next_jabber   = wr_ten ? wr_data_in[`PTD_BIT_JABBER] : jabber;
      next_err_run  = err_run;
      next_err_held = err_held;
      if (prbs_byte_err_in) begin
         if (!(cnt_stop_mode_in && (err_run == `PTD_CNT_MAX))) begin
            next_err_run = err_run + 8'h01;
         end
      end
      // The clear acts at the write edge, so an error in that cycle is the first new count.
      if (wr_cnt && wr_data_in[`PTD_BIT_CNT_LOCK]) begin
         next_err_held = err_run;
         next_err_run  = prbs_byte_err_in ? 8'h01 : 8'h00;
      end
      next_gap       = wr_cnt ? wr_data_in[7:0] : gap;
      next_frame_len = wr_len ? wr_data_in[10:0] : frame_len;
      next_diag_start = diag_start;
      next_rescal     = rescal;
      next_diag_done  = diag_done;
      next_diag_fail  = diag_fail;
      if (wr_diag) begin
         next_diag_start = wr_data_in[`PTD_BIT_DIAG_START];
         next_rescal     = wr_data_in[`PTD_BIT_RESCAL];
         if (wr_data_in[`PTD_BIT_DIAG_START]) begin
            next_diag_done = 1'b0;
            next_diag_fail = 1'b0;
         end
      end
      if (diag_done_in) begin
         next_diag_done  = 1'b1;
         next_diag_start = 1'b0;
      end
      if (diag_fail_in) begin
         next_diag_fail = 1'b1;
      end
      next_mled_swap  = wr_mled ? wr_data_in[`PTD_BIT_MLED_SWAP] : mled_swap;
      next_mled_cfg   = wr_mled ? wr_data_in[6:3] : mled_cfg;
      next_mled_route = wr_mled ? wr_data_in[0] : mled_route;

      // The software hard reset holds every register except the read data, the strap level and the reset control at its reset value while the pulse stands.
      // Writes that land during the pulse are lost, as they would be under the reset pin.
      if (hard_rst) begin
         next_strap_taken = 1'b0;
         next_strap_wait  = 3'h0;
         next_polarity    = 1'b0;
         next_jabber      = 1'b0;
         next_err_run     = 8'h00;
         next_err_held    = 8'h00;
         next_gap         = `PTD_RST_GAP;
         next_frame_len   = `PTD_RST_LEN;
         next_diag_start  = 1'b0;
         next_rescal      = 1'b0;
         next_diag_done   = 1'b0;
         next_diag_fail   = 1'b0;
         next_mled_swap   = MLED_RST[`PTD_BIT_MLED_SWAP];
         next_mled_cfg    = MLED_RST[6:3];
         next_mled_route  = MLED_RST[0];
      end
      // Self-clearing reset pulses are held a few cycles so slow blocks see them.
      next_rst_state = rst_state;
      next_pulse_cnt = pulse_cnt;
      next_hard_rst  = hard_rst;
      next_soft_rst  = soft_rst;
      case (rst_state)
         ptd_pkg::PTD_RST_IDLE: begin
            if (wr_rst && (wr_data_in[`PTD_BIT_HARD_RST] || wr_data_in[`PTD_BIT_SOFT_RST])) begin
               next_hard_rst  = wr_data_in[`PTD_BIT_HARD_RST];
               next_soft_rst  = wr_data_in[`PTD_BIT_SOFT_RST];
               next_pulse_cnt = PULSE_CYC;
               next_rst_state = ptd_pkg::PTD_RST_PULSE;
            end
         end
         ptd_pkg::PTD_RST_PULSE: begin
            next_pulse_cnt = pulse_cnt - 4'h1;
            if (pulse_cnt == 4'h1) begin
               next_hard_rst  = 1'b0;
               next_soft_rst  = 1'b0;
               next_rst_state = ptd_pkg::PTD_RST_IDLE;
            end
         end
         default: begin
            next_rst_state = ptd_pkg::PTD_RST_IDLE;
         end
      endcase
      // Read data is held between reads so a slow host may fetch it late.
      next_rd_data = 16'h0000;
      if (rd_strobe_in) begin
         case (addr_in)
            {1'b0, `PTD_OFS_TEN_MEG}:    next_rd_data = {11'h000, polarity, 3'h0, jabber};
            {1'b0, `PTD_OFS_BIST_CNT}:   next_rd_data = {err_held, gap};
            {1'b0, `PTD_OFS_BIST_LEN}:   next_rd_data = {5'h00, frame_len};
            {1'b0, `PTD_OFS_CABLE_DIAG}: next_rd_data = {diag_start, rescal, 12'h000, diag_done, diag_fail};
            {1'b0, `PTD_OFS_PHY_RESET}:  next_rd_data = {hard_rst, soft_rst, 14'h0000};
            `PTD_OFS_MLED:               next_rd_data = {6'h00, mled_swap, 2'h0, mled_cfg, 2'h0, mled_route};
            default:                     next_rd_data = 16'h0000;
         endcase
      end else begin
         next_rd_data = rd_data_out;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         strap_taken <= 1'b0;
         strap_wait  <= 3'h0;
         strap_high  <= 1'b0;
         polarity    <= 1'b0;
         jabber      <= 1'b0;
         err_run     <= 8'h00;
         err_held    <= 8'h00;
         gap         <= `PTD_RST_GAP;
         frame_len   <= `PTD_RST_LEN;
         diag_start  <= 1'b0;
         rescal      <= 1'b0;
         diag_done   <= 1'b0;
         diag_fail   <= 1'b0;
         mled_swap   <= MLED_RST[`PTD_BIT_MLED_SWAP];
         mled_cfg    <= MLED_RST[6:3];
         mled_route  <= MLED_RST[0];
         hard_rst    <= 1'b0;
         soft_rst    <= 1'b0;
         pulse_cnt   <= 4'h0;
         rst_state   <= ptd_pkg::PTD_RST_IDLE;
         rd_data_out <= 16'h0000;
      end else begin
         strap_taken <= next_strap_taken;
         strap_wait  <= next_strap_wait;
         strap_high  <= next_strap_high;
         polarity    <= next_polarity;
         jabber      <= next_jabber;
         err_run     <= next_err_run;
         err_held    <= next_err_held;
         gap         <= next_gap;
         frame_len   <= next_frame_len;
         diag_start  <= next_diag_start;
         rescal      <= next_rescal;
         diag_done   <= next_diag_done;
         diag_fail   <= next_diag_fail;
         mled_swap   <= next_mled_swap;
         mled_cfg    <= next_mled_cfg;
         mled_route  <= next_mled_route;
         hard_rst    <= next_hard_rst;
         soft_rst    <= next_soft_rst;
         pulse_cnt   <= next_pulse_cnt;
         rst_state   <= next_rst_state;
         rd_data_out <= next_rd_data;
      end
   end

   // ************************************************************************
   // Output registers.
   // ************************************************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         polarity_status_out      <= 1'b0;
         jabber_disable_out       <= 1'b0;
         selftest_gap_bytes_out   <= {`PTD_RST_GAP, 2'b00};
         selftest_frame_bytes_out <= `PTD_RST_LEN;
         diag_start_out           <= 1'b0;
         rescal_start_out         <= 1'b0;
         hard_reset_out           <= 1'b0;
         soft_restart_out         <= 1'b0;
         mled_active_low_out      <= 1'b0;
         mled_config_out          <= MLED_RST[6:3];
         mled_route_out           <= MLED_RST[0];
      end else begin
         polarity_status_out      <= polarity;
         // The disable only matters at 10M, so it is gated here for the jabber timer.
         jabber_disable_out       <= jabber && speed_10m_in;
         selftest_gap_bytes_out   <= {gap, 2'b00};
         selftest_frame_bytes_out <= frame_len;
         diag_start_out           <= diag_start;
         rescal_start_out         <= rescal;
         hard_reset_out           <= hard_rst;
         soft_restart_out         <= soft_rst;
         mled_active_low_out      <= strap_high ^ mled_swap;
         mled_config_out          <= mled_cfg;
         mled_route_out           <= mled_route;
      end
   end
endmodule

// [ptd_regs_chk.sv]
/* Port checks for the management register group.
   Assumes a bind to every ptd_regs instance, one clock and reset. */
module ptd_regs_chk (
   input wire logic               clk_sys_in,
   input wire logic               rst_in,
   input wire logic               wr_strobe_in,
   input wire logic               rd_strobe_in,
   input wire ptd_pkg::ptd_addr_t addr_in,
   input wire ptd_pkg::ptd_word_t wr_data_in,
   input wire ptd_pkg::ptd_word_t rd_data_out,
   input wire logic               polarity_inverted_in,
   input wire logic               speed_10m_in,
   input wire logic               diag_done_in,
   input wire logic               polarity_status_out,
   input wire logic               jabber_disable_out,
   input wire logic [9:0]         selftest_gap_bytes_out,
   input wire logic               diag_start_out,
   input wire logic               hard_reset_out,
   input wire logic               soft_restart_out
);
   // ****
   // Checks.
   // ****
   logic [7:0] gap_wr;
   assign gap_wr = wr_data_in[7:0];
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   chk_polarity_sticky: assert property (polarity_inverted_in ##1 !rd_strobe_in [*2]
      |-> polarity_status_out)
      else $error("polarity status not set");
   chk_jabber_speed_gate: assert property (!speed_10m_in [*3] |-> !jabber_disable_out)
      else $error("jabber disable outside 10M");
   chk_gap_times_four: assert property (wr_strobe_in && addr_in == 6'h1B
      |-> ##2 selftest_gap_bytes_out == {$past(gap_wr, 2), 2'b00})
      else $error("gap bytes wrong");
   chk_diag_start_clear: assert property (diag_done_in ##1 !wr_strobe_in [*3] |-> !diag_start_out)
      else $error("start not cleared by done");
   chk_hard_pulse_len: assert property ($rose(hard_reset_out)
      |-> ##1 hard_reset_out ##1 !hard_reset_out)
      else $error("hard reset pulse length");
   chk_soft_pulse_len: assert property ($rose(soft_restart_out)
      |-> ##1 soft_restart_out ##1 !soft_restart_out)
      else $error("soft restart pulse length");
   chk_unmapped_zero: assert property (rd_strobe_in && addr_in == 6'h00 |=> ##[0:1] rd_data_out == 16'h0000)
      else $error("unmapped read not zero");
   chk_read_data_hold: assert property (!rd_strobe_in [*2] |=> $stable(rd_data_out))
      else $error("read data changed without read");
endmodule
bind ptd_regs ptd_regs_chk i_chk (.*);

// [ptd_host_model.sv]
/* Management host model issuing one-cycle strobes on falling edges.
   Assumes the register group samples strobes on rising edges. */
module ptd_host_model (
   input  wire logic               clk_sys_in,
   input  wire ptd_pkg::ptd_word_t rd_data_in,
   output logic                    wr_strobe_out,
   output logic                    rd_strobe_out,
   output ptd_pkg::ptd_addr_t      addr_out,
   output ptd_pkg::ptd_word_t      wr_data_out
);
   // ****
   // Bus cycles.
   // ****
   initial begin
      wr_strobe_out = 1'b0;
      rd_strobe_out = 1'b0;
      addr_out = 6'h3F;
      wr_data_out = 16'hA5A5;
   end
   // Writes of one to lock, start and reset bits pass here.
   task automatic wr(input ptd_pkg::ptd_addr_t a, input ptd_pkg::ptd_word_t d);
      @(negedge clk_sys_in);
      addr_out = a;
      wr_data_out = d;
      wr_strobe_out = 1'b1;
      @(negedge clk_sys_in);
      wr_strobe_out = 1'b0;
      addr_out = ~a;
      wr_data_out = ~d;
   endtask
   // Data is taken a full cycle late since it is held until the next read.
   task automatic rd(input ptd_pkg::ptd_addr_t a, output ptd_pkg::ptd_word_t d);
      @(negedge clk_sys_in);
      addr_out = a;
      rd_strobe_out = 1'b1;
      @(negedge clk_sys_in);
      rd_strobe_out = 1'b0;
      addr_out = ~a;
      @(negedge clk_sys_in);
      d = rd_data_in;
   endtask
endmodule

// [phy_test_diag_control_regs_tb.sv]
/* Self-checking bench for the management register group.
   Assumes the host model and checker files are compiled first. */
module phy_test_diag_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Bench.
   // ****
   logic clk_sys_in, rst_in, wr_s, rd_s, pol, st_rd, spd, err, stop, done, fail, strap;
   logic [5:0] addr;
   logic [15:0] wd, rdd;
   logic pol_o, jab_o, ds_o, rc_o, hr_o, sr_o, al_o, rt_o;
   logic [9:0] gap_o;
   logic [10:0] len_o;
   logic [3:0] cfg_o;
   int error_cnt = 0;
   int checks = 0;
   ptd_host_model i_host (.clk_sys_in(clk_sys_in), .rd_data_in(rdd), .wr_strobe_out(wr_s),
      .rd_strobe_out(rd_s), .addr_out(addr), .wr_data_out(wd));
   ptd_regs i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wr_strobe_in(wr_s), .rd_strobe_in(rd_s),
      .addr_in(addr), .wr_data_in(wd), .rd_data_out(rdd), .polarity_inverted_in(pol),
      .phy_status_rd_in(st_rd), .speed_10m_in(spd), .prbs_byte_err_in(err), .cnt_stop_mode_in(stop),
      .diag_done_in(done), .diag_fail_in(fail), .col_strap_pin_in(strap), .polarity_status_out(pol_o),
      .jabber_disable_out(jab_o), .selftest_gap_bytes_out(gap_o), .selftest_frame_bytes_out(len_o),
      .diag_start_out(ds_o), .rescal_start_out(rc_o), .hard_reset_out(hr_o), .soft_restart_out(sr_o),
      .mled_active_low_out(al_o), .mled_config_out(cfg_o), .mled_route_out(rt_o));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input ptd_pkg::ptd_addr_t a, input logic [15:0] exp);
      ptd_pkg::ptd_word_t d;
      i_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic pulse(ref logic s, input int n);
      repeat (n) begin
         @(negedge clk_sys_in);
         s = 1'b1;
         @(negedge clk_sys_in);
         s = 1'b0;
      end
      repeat (3) @(negedge clk_sys_in);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_reset();
      rchk(6'h1B, 16'h007D);
      rchk(6'h1C, 16'h05EE);
      chk({gap_o, 6'h00}, {10'h1F4, 6'h00});
      chk({5'h00, len_o}, 16'h05EE);
      chk({al_o, rt_o, cfg_o, 10'h000}, 16'h6000);
      rchk(6'h00, 16'h0000);
      $display("reset values done");
   endtask
   task automatic t_polarity();
      pulse(pol, 1);
      pulse(st_rd, 1);
      chk({15'h0000, pol_o}, 16'h0001);
      rchk(6'h1A, 16'h0010);
      rchk(6'h1A, 16'h0000);
      i_host.wr(6'h1A, 16'hFFFF);
      rchk(6'h1A, 16'h0001);
      chk({15'h0000, jab_o}, 16'h0001);
      spd = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      chk({15'h0000, jab_o}, 16'h0000);
      $display("polarity and jabber done");
   endtask
   task automatic t_count();
      stop = 1'b1;
      pulse(err, 300);
      i_host.wr(6'h1B, 16'h8010);
      rchk(6'h1B, 16'hFF10);
      chk({gap_o, 6'h00}, {10'h040, 6'h00});
      stop = 1'b0;
      pulse(err, 260);
      i_host.wr(6'h1B, 16'h8010);
      rchk(6'h1B, 16'h0410);
      $display("error count done");
   endtask
   task automatic t_diag();
      i_host.wr(6'h1C, 16'hFFFF);
      rchk(6'h1C, 16'h07FF);
      i_host.wr(6'h1E, 16'hC000);
      repeat (2) @(negedge clk_sys_in);
      chk({14'h0000, ds_o, rc_o}, 16'h0003);
      pulse(done, 1);
      rchk(6'h1E, 16'h4002);
      i_host.wr(6'h1E, 16'h8000);
      pulse(fail, 1);
      pulse(done, 1);
      i_host.wr(6'h1E, 16'h3FFF);
      rchk(6'h1E, 16'h0003);
      $display("cable diagnostics done");
   endtask
   task automatic t_rst_ctl(input logic [15:0] d);
      int nh;
      int ns;
      nh = 0;
      ns = 0;
      i_host.wr(6'h1F, d);
      repeat (8) begin
         @(negedge clk_sys_in);
         nh += int'(hr_o);
         ns += int'(sr_o);
      end
      chk({nh[7:0], ns[7:0]}, d[15] ? 16'h0200 : 16'h0002);
      rchk(6'h1F, 16'h0000);
      $display("reset control done");
   endtask
   task automatic t_led();
      i_host.wr(6'h25, 16'hFFFF);
      rchk(6'h25, 16'h0279);
      chk({al_o, rt_o, cfg_o, 10'h000}, 16'hFC00);
      $display("led control done");
   endtask
   task automatic t_strap();
      i_host.wr(6'h1C, 16'h0123);
      @(negedge clk_sys_in);
      strap = 1'b1;
      rst_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      rst_in = 1'b0;
      repeat (8) @(negedge clk_sys_in);
      chk({al_o, rt_o, cfg_o, 10'h000}, 16'hE000);
      rchk(6'h25, 16'h0041);
      rchk(6'h1C, 16'h05EE);
      i_host.wr(6'h25, 16'h0241);
      repeat (2) @(negedge clk_sys_in);
      chk({al_o, rt_o, cfg_o, 10'h000}, 16'h6000);
      $display("strap and mid-run reset done");
   endtask
   initial begin
      rst_in = 1'b1;
      {pol, st_rd, err, stop, done, fail, strap} = 7'h00;
      spd = 1'b1;
      repeat (16) @(negedge clk_sys_in);
      rst_in = 1'b0;
      t_reset();
      t_polarity();
      t_count();
      t_diag();
      t_rst_ctl(16'h4000);
      rchk(6'h1C, 16'h07FF);
      t_rst_ctl(16'h8000);
      rchk(6'h1C, 16'h05EE);
      t_led();
      t_strap();
      stop_test();
   end
   initial begin
      #500us;
      error_cnt++;
      stop_test();
   end
endmodule
